// ---- logic/psd_sram.v ----
`timescale 1ns/1ns
`include "psd_defs.vh"

module psd_sram (
  // System
  input  wire                   clock,
  input  wire                   resetn,
  input  wire                   clk_en,
  // Memory controller pins
  input  wire                   clk_qualify_n,
  input  wire                   chip_select1_n,
  input  wire                   chip_select2,
  input  wire                   chip_select3_n,
  input  wire                   advance_load,
  input  wire                   write_n,
  input  wire [`PSD_PW-1:0]     byte_lane_write_n,
  input  wire [`PSD_AW-1:0]     addr,
  input  wire                   out_enable_n,
  input  wire [`PSD_DW-1:0]     dq_in,
  output wire [`PSD_DW-1:0]     dq_out,
  output wire                   dq_oe,
  input  wire [`PSD_PW-1:0]     parity_lane_in,
  output wire [`PSD_PW-1:0]     parity_lane_out,
  output wire                   parity_lane_oe,
  // Burst-order strap
  input  wire                   mode_strap,
  // Test port
  input  wire                   tck,
  input  wire                   tms,
  input  wire                   tdi,
  output wire                   tdo,
  output wire                   tdo_oe,
  // Avalon-MM slave
  input  wire [`PSD_BUS_AW-1:0] avs_address,
  input  wire                   avs_read,
  input  wire                   avs_write,
  input  wire [31:0]            avs_writedata,
  output reg  [31:0]            avs_readdata,
  output wire                   avs_waitrequest
);

  reg  [`PSD_WW-1:0]     mem [0:`PSD_DEPTH-1];
  reg  [2:0]             strap_sync;
  reg                    strap_lvl;
  reg                    s1_valid;
  reg                    s1_write;
  reg  [`PSD_AW-1:0]     s1_addr;
  reg  [`PSD_BCNT_W-1:0] s1_base;
  reg  [`PSD_BCNT_W-1:0] s1_cnt;
  reg  [`PSD_PW-1:0]     s1_bw;
  reg                    s2_write;
  reg  [`PSD_AW-1:0]     s2_addr;
  reg  [`PSD_PW-1:0]     s2_bw;
  reg                    wpend;
  reg  [`PSD_AW-1:0]     waddr;
  reg  [`PSD_PW-1:0]     wbw;
  reg  [`PSD_WW-1:0]     wdata;
  reg  [`PSD_WW-1:0]     dout;
  reg                    out_valid;
  reg                    ctrl_oe;
  reg  [`PSD_WCNT_W-1:0] wcount;
  reg                    rd_done;
  reg  [`PSD_WW-1:0]     next_dout;
  wire                   core_ce;
  wire                   selected;
  wire                   drive;
  wire                   tap_reset;
  wire [`PSD_BCNT_W-1:0] next_cnt;
  wire [`PSD_WW-1:0]     lane_word;
  integer                i;

  // Burst position: interleaved order xors, linear order adds
  function [`PSD_BCNT_W-1:0] burst_lo;
    input [`PSD_BCNT_W-1:0] base;
    input [`PSD_BCNT_W-1:0] cnt;
    input                   ilv;
    begin
      burst_lo = ilv ? (base ^ cnt) : (base + cnt);
    end
  endfunction

  // Byte-wise merge; each parity bit follows its byte's select
  function [`PSD_WW-1:0] merge;
    input [`PSD_WW-1:0] old;
    input [`PSD_WW-1:0] neu;
    input [`PSD_PW-1:0] bw_n;
    integer b;
    begin
      merge = old;
      for (b = 0; b < `PSD_PW; b = b + 1) begin
        if (!bw_n[b]) begin
          merge[b*`PSD_BL +: `PSD_BL] = neu[b*`PSD_BL +: `PSD_BL];
          merge[`PSD_DW + b]          = neu[`PSD_DW + b];
        end
      end
    end
  endfunction

  // Same-clock controller pins need no synchroniser
  assign core_ce   = clk_en & ~clk_qualify_n;
  assign selected  = ~chip_select1_n & chip_select2 & ~chip_select3_n;
  assign next_cnt  = s1_cnt + `PSD_BCNT_ONE;
  assign lane_word = {parity_lane_in, dq_in};

  // Output enable is asynchronous; internal control comes from registers
  assign drive = out_valid & ~out_enable_n & ctrl_oe;
  assign dq_oe           = drive;
  assign parity_lane_oe  = drive;
  assign dq_out          = dout[`PSD_DW-1:0];
  assign parity_lane_out = dout[`PSD_WW-1:`PSD_DW];

  // Read word with forwarding from writes not yet in the array
  always @* begin
    next_dout = mem[s1_addr];
    if (wpend && (waddr == s1_addr))
      next_dout = merge(next_dout, wdata, wbw);
    if (s2_write && (s2_addr == s1_addr))
      next_dout = merge(next_dout, lane_word, s2_bw);
  end

  // Strap: three stages, default high until a level is seen
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_sync <= {3{`PSD_STRAP_RST}};
      strap_lvl  <= `PSD_STRAP_RST;
    end else if (clk_en) begin
      strap_sync <= {strap_sync[1:0], mode_strap};
      if (strap_sync[1] == strap_sync[2])
        strap_lvl <= strap_sync[2];
    end
  end

  // Command stage
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s1_valid <= 1'b0;
      s1_write <= 1'b0;
      s1_addr  <= `PSD_ADDR_RST;
      s1_base  <= `PSD_BCNT_RST;
      s1_cnt   <= `PSD_BCNT_RST;
      s1_bw    <= `PSD_BW_RST;
    end else if (core_ce) begin
      if (!advance_load) begin
        s1_valid <= selected;
        s1_write <= ~write_n;
        s1_addr  <= addr;
        s1_base  <= addr[`PSD_BCNT_W-1:0];
        s1_cnt   <= `PSD_BCNT_RST;
        s1_bw    <= byte_lane_write_n | {`PSD_PW{write_n}};
      end else if (s1_valid) begin
        // Burst continues the latched access type
        s1_cnt <= next_cnt;
        s1_addr[`PSD_BCNT_W-1:0] <= burst_lo(s1_base, next_cnt,
                                             strap_lvl);
        s1_bw  <= byte_lane_write_n | {`PSD_PW{~s1_write}};
      end
    end
  end

  // Data phase, write capture and self-timed array write
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s2_write  <= 1'b0;
      s2_addr   <= `PSD_ADDR_RST;
      s2_bw     <= `PSD_BW_RST;
      wpend     <= 1'b0;
      waddr     <= `PSD_ADDR_RST;
      wbw       <= `PSD_BW_RST;
      wdata     <= `PSD_WORD_RST;
      dout      <= `PSD_WORD_RST;
      out_valid <= 1'b0;
      wcount    <= `PSD_WCNT_RST;
    end else if (core_ce) begin
      s2_write <= s1_valid & s1_write;
      s2_addr  <= s1_addr;
      s2_bw    <= s1_bw;
      // Write and deselect commands float the lanes for their data phase clock
      out_valid <= s1_valid & ~s1_write;
      if (s1_valid && !s1_write)
        dout <= next_dout;
      wpend <= s2_write;
      if (s2_write) begin
        wdata <= lane_word;
        waddr <= s2_addr;
        wbw   <= s2_bw;
      end
      if (wpend)
        wcount <= wcount + `PSD_WCNT_ONE;
    end
  end

  always @(posedge clock) begin
    if (resetn && core_ce && wpend)
      mem[waddr] <= merge(mem[waddr], wdata, wbw);
  end

  // Register slave: reads take one wait state, writes take none
  assign avs_waitrequest = avs_read & ~rd_done;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_oe      <= `PSD_CTRL_RST;
      rd_done      <= 1'b0;
      avs_readdata <= `PSD_DATA_ZERO;
    end else if (clk_en) begin
      rd_done <= avs_read & ~rd_done;
      if (avs_write && avs_address == `PSD_REG_CTRL)
        ctrl_oe <= avs_writedata[`PSD_CTRL_OE];
      if (avs_read && !rd_done) begin
        avs_readdata <= `PSD_DATA_ZERO;
        case (avs_address)
          `PSD_REG_CTRL: avs_readdata[`PSD_CTRL_OE] <= ctrl_oe;
          `PSD_REG_STAT: begin
            avs_readdata[`PSD_ST_ILV] <= strap_lvl;
            avs_readdata[`PSD_ST_DRV] <= drive;
            avs_readdata[`PSD_ST_SEL] <= s1_valid;
            avs_readdata[`PSD_ST_TAP] <= tap_reset;
          end
          `PSD_REG_WCNT: avs_readdata[`PSD_WCNT_W-1:0] <= wcount;
          default: avs_readdata <= `PSD_DATA_ZERO;
        endcase
      end
    end
  end

  psd_tap u_tap (
    .clock     (clock),
    .resetn    (resetn),
    .clk_en    (clk_en),
    .tck       (tck),
    .tms       (tms),
    .tdi       (tdi),
    .tdo       (tdo),
    .tdo_oe    (tdo_oe),
    .tap_reset (tap_reset)
  );

  initial begin
    for (i = 0; i < `PSD_DEPTH; i = i + 1)
      mem[i] = `PSD_WORD_RST;
  end

endmodule

// ---- inc/psd_defs.vh ----
`ifndef PSD_DEFS_VH
`define PSD_DEFS_VH

// Data path geometry
`define PSD_DW        32
`define PSD_PW        4
`define PSD_WW        36
`define PSD_BL        8
`define PSD_AW        4
`define PSD_DEPTH     16
`define PSD_BCNT_W    2

// Register bus
`define PSD_BUS_AW    4
`define PSD_REG_CTRL  4'h0
`define PSD_REG_STAT  4'h4
`define PSD_REG_WCNT  4'h8
`define PSD_CTRL_OE   0
`define PSD_ST_ILV    0
`define PSD_ST_DRV    1
`define PSD_ST_SEL    2
`define PSD_ST_TAP    3
`define PSD_WCNT_W    16

// Reset values
`define PSD_CTRL_RST  1'b1
`define PSD_STRAP_RST 1'b1
`define PSD_SYNC_RST  3'h0
`define PSD_WORD_RST  36'h0
`define PSD_ADDR_RST  4'h0
`define PSD_BW_RST    4'hF
`define PSD_BCNT_RST  2'h0
`define PSD_BCNT_ONE  2'h1
`define PSD_WCNT_RST  16'h0000
`define PSD_WCNT_ONE  16'h0001
`define PSD_DATA_ZERO 32'h00000000

// Test port
`define PSD_IR_W      2
`define PSD_IR_CAP    2'h1
`define PSD_IR_RST    2'h3
`define PSD_SYN_TCK   0
`define PSD_SYN_TMS   1
`define PSD_SYN_TDI   2

`endif

// ---- logic/psd_tap.v ----
`timescale 1ns/1ns
`include "psd_defs.vh"

module psd_tap (
  // System
  input  wire        clock,
  input  wire        resetn,
  input  wire        clk_en,
  // Test pins
  input  wire        tck,
  input  wire        tms,
  input  wire        tdi,
  output reg         tdo,
  output reg         tdo_oe,
  // Status
  output wire        tap_reset
);

  localparam [15:0] ST_TLR = 16'h0001, ST_RTI = 16'h0002,
                    ST_SDR = 16'h0004, ST_CDR = 16'h0008,
                    ST_SHD = 16'h0010, ST_E1D = 16'h0020,
                    ST_PSD = 16'h0040, ST_E2D = 16'h0080,
                    ST_UDR = 16'h0100, ST_SIR = 16'h0200,
                    ST_CIR = 16'h0400, ST_SHI = 16'h0800,
                    ST_E1I = 16'h1000, ST_PSI = 16'h2000,
                    ST_E2I = 16'h4000, ST_UIR = 16'h8000;

  reg  [2:0]             sync1;
  reg  [2:0]             sync2;
  reg  [2:0]             sync3;
  reg  [2:0]             lvl;
  reg  [15:0]            state;
  reg  [15:0]            next_state;
  reg  [`PSD_IR_W-1:0]   ir;
  reg                    bypass;
  wire [2:0]             agree;
  wire [2:0]             next_lvl;
  wire                   tck_rise;
  wire                   tck_fall;
  reg                    tck_rise_d;

  // A pin level counts once the second and third stages agree
  assign agree    = ~(sync2 ^ sync3);
  assign next_lvl = (sync3 & agree) | (lvl & ~agree);
  assign tck_rise = next_lvl[`PSD_SYN_TCK] & ~lvl[`PSD_SYN_TCK];
  assign tck_fall = ~next_lvl[`PSD_SYN_TCK] & lvl[`PSD_SYN_TCK];
  assign tap_reset = state[0];

  always @* begin
    next_state = state;
    case (state)
      ST_TLR: next_state = lvl[`PSD_SYN_TMS] ? ST_TLR : ST_RTI;
      ST_RTI: next_state = lvl[`PSD_SYN_TMS] ? ST_SDR : ST_RTI;
      ST_SDR: next_state = lvl[`PSD_SYN_TMS] ? ST_SIR : ST_CDR;
      ST_CDR: next_state = lvl[`PSD_SYN_TMS] ? ST_E1D : ST_SHD;
      ST_SHD: next_state = lvl[`PSD_SYN_TMS] ? ST_E1D : ST_SHD;
      ST_E1D: next_state = lvl[`PSD_SYN_TMS] ? ST_UDR : ST_PSD;
      ST_PSD: next_state = lvl[`PSD_SYN_TMS] ? ST_E2D : ST_PSD;
      ST_E2D: next_state = lvl[`PSD_SYN_TMS] ? ST_UDR : ST_SHD;
      ST_UDR: next_state = lvl[`PSD_SYN_TMS] ? ST_SDR : ST_RTI;
      ST_SIR: next_state = lvl[`PSD_SYN_TMS] ? ST_TLR : ST_CIR;
      ST_CIR: next_state = lvl[`PSD_SYN_TMS] ? ST_E1I : ST_SHI;
      ST_SHI: next_state = lvl[`PSD_SYN_TMS] ? ST_E1I : ST_SHI;
      ST_E1I: next_state = lvl[`PSD_SYN_TMS] ? ST_UIR : ST_PSI;
      ST_PSI: next_state = lvl[`PSD_SYN_TMS] ? ST_E2I : ST_PSI;
      ST_E2I: next_state = lvl[`PSD_SYN_TMS] ? ST_UIR : ST_SHI;
      ST_UIR: next_state = lvl[`PSD_SYN_TMS] ? ST_SDR : ST_RTI;
      default: next_state = ST_TLR;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1  <= `PSD_SYNC_RST;
      sync2  <= `PSD_SYNC_RST;
      sync3  <= `PSD_SYNC_RST;
      lvl    <= `PSD_SYNC_RST;
      state  <= ST_TLR;
      ir     <= `PSD_IR_RST;
      bypass <= 1'b0;
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
      tck_rise_d <= 1'b0;
    end else if (clk_en) begin
      sync1 <= {tdi, tms, tck};
      sync2 <= sync1;
      sync3 <= sync2;
      lvl   <= next_lvl;
      // Act one clock after the rise so mode and data levels have settled
      tck_rise_d <= tck_rise;
      if (tck_rise_d) begin
        // Mode select and serial input taken on the rising test clock
        state <= next_state;
        if (state == ST_CDR)
          bypass <= 1'b0;
        else if (state == ST_SHD)
          bypass <= lvl[`PSD_SYN_TDI];
        if (state == ST_CIR)
          ir <= `PSD_IR_CAP;
        else if (state == ST_SHI)
          ir <= {lvl[`PSD_SYN_TDI], ir[`PSD_IR_W-1:1]};
      end
      if (tck_fall) begin
        // Serial output changes only on the falling test clock
        tdo    <= (state == ST_SHI) ? ir[0] : bypass;
        tdo_oe <= (state == ST_SHD) | (state == ST_SHI);
      end
    end
  end

endmodule

// ---- verif/psd_sram_assertions.sv ----
`timescale 1ns/1ns
`include "psd_defs.vh"
module psd_chk (
  // System
  input wire               clock,
  input wire               resetn,
  input wire               clk_en,
  // Memory pins
  input wire               clk_qualify_n,
  input wire               chip_select1_n,
  input wire               chip_select2,
  input wire               chip_select3_n,
  input wire               advance_load,
  input wire               write_n,
  input wire               out_enable_n,
  input wire [`PSD_DW-1:0] dq_out,
  input wire               dq_oe,
  input wire               parity_lane_oe,
  // Test port and bus
  input wire               tck,
  input wire               tdo,
  input wire               tdo_oe,
  input wire               avs_read,
  input wire               avs_write,
  input wire               avs_waitrequest
);
  wire run;
  wire sel;
  assign run = clk_en & ~clk_qualify_n;
  assign sel = ~chip_select1_n & chip_select2 & ~chip_select3_n;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_idle_hold: assert property (!run |=> $stable(dq_out))
    else $error("read word moved without an active edge");
  a_stretch_oe: assert property
    (clk_en && clk_qualify_n ##1 $stable(out_enable_n) |-> $stable(dq_oe))
    else $error("drive changed in a stretched cycle");
  a_oe_off: assert property (out_enable_n |-> !dq_oe)
    else $error("lanes driven with output enable high");
  a_par_lane: assert property (parity_lane_oe == dq_oe)
    else $error("parity drive differs from data drive");
  a_write_float: assert property
    (run && sel && !advance_load && !write_n ##1 run |=> !dq_oe)
    else $error("lanes driven in write data phase");
  a_desel_float: assert property
    (run && !sel && !advance_load ##1 run |=> !dq_oe)
    else $error("lanes driven after deselect");
  a_bus_wait: assert property
    (avs_read && clk_en && avs_waitrequest |=> !avs_waitrequest)
    else $error("read answer later than one cycle");
  a_bus_write: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  a_tdo_edge: assert property
    ($changed(tdo) || $changed(tdo_oe) |-> !tck)
    else $error("serial output moved while test clock high");
endmodule

// ---- verif/psd_ctl_model.sv ----
`timescale 1ns/1ns
`include "psd_defs.vh"
module psd_ctl_model (
  // System
  input  wire               clock,
  input  wire               resetn,
  input  wire               clk_en,
  // Command pins as driven
  input  wire               clk_qualify_n,
  input  wire               sel,
  input  wire               advance_load,
  input  wire               write_n,
  // Data lanes
  input  wire [`PSD_WW-1:0] wdata,
  input  wire [`PSD_WW-1:0] rd_word,
  input  wire               dev_drv,
  output wire [`PSD_WW-1:0] lanes
);
  reg               wtype;
  reg  [1:0]        pend;
  reg  [`PSD_WW-1:0] d1;
  reg  [`PSD_WW-1:0] d2;
  reg  [`PSD_WW-1:0] last;
  wire              run;
  wire              wcmd;
  assign run = clk_en & ~clk_qualify_n;
  assign wcmd = advance_load ? wtype : sel & ~write_n;
  // Released lanes toggle so a stale value is never mistaken for data
  assign lanes = pend[1] ? d2 : dev_drv ? rd_word : ~last;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wtype <= 1'b0;
      pend <= 2'b00;
      last <= 36'h0;
    end else begin
      last <= lanes;
      if (run) begin
        if (!advance_load) begin
          wtype <= sel & ~write_n;
        end
        pend <= {pend[0], wcmd};
        d1 <= wdata;
        d2 <= d1;
      end
    end
  end
endmodule

// ---- verif/test_pipelined_sram_data_port.sv ----
`timescale 1ns/1ns
`include "psd_defs.vh"
module test_pipelined_sram_data_port;
  reg         clock, resetn, clk_en, clk_qualify_n, advance_load, write_n;
  reg  [2:0]  cs;
  reg  [3:0]  bw_n, addr, avs_address, base;
  reg         out_enable_n, mode_strap, tck, tms, tdi, avs_read, avs_write;
  reg  [31:0] avs_writedata, r;
  reg  [35:0] wdata, mem [0:15];
  reg  [1:0]  bc;
  reg         cur_w, active, ctrl_on, oe_n;
  wire [31:0] dq_in, dq_out, avs_readdata;
  wire [3:0]  par_in, par_out;
  wire        dq_oe, par_oe, tdo, tdo_oe, avs_waitrequest;
  integer     fails, checks, cyc, wcnt, i;
  reg  [35:0] mq [$];
  reg  [31:0] bq [$];
  psd_sram psd_sram_i (.clock, .resetn, .clk_en, .clk_qualify_n,
    .chip_select1_n(cs[2]), .chip_select2(cs[1]), .chip_select3_n(cs[0]),
    .advance_load, .write_n, .byte_lane_write_n(bw_n), .addr, .out_enable_n,
    .dq_in, .dq_out, .dq_oe, .parity_lane_in(par_in),
    .parity_lane_out(par_out), .parity_lane_oe(par_oe), .mode_strap, .tck,
    .tms, .tdi, .tdo, .tdo_oe, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  psd_ctl_model psd_ctl_model_i (.clock, .resetn, .clk_en, .clk_qualify_n,
    .sel(cs == 3'b010), .advance_load, .write_n, .wdata,
    .rd_word({par_out, dq_out}), .dev_drv(dq_oe), .lanes({par_in, dq_in}));
  task check(input [35:0] seen, input [35:0] exp, input string what);
    checks = checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[ERR] %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task bus(input w, input [3:0] a, input [31:0] d, input [31:0] e);
    if (!w) bq.push_back(e);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  // One command; a random stall cycle with junk pins may come first
  task op(input s, input w, input adv, input rb, input [3:0] a);
    reg [35:0] d;
    reg [3:0]  ea;
    integer    k;
    r = $urandom;
    if (r[31:30] == 2'b00) begin
      {clk_en, clk_qualify_n} <= r[0] ? 2'b11 : 2'b00;
      addr <= r[7:4];
      write_n <= r[8];
      advance_load <= r[9];
      cs <= r[12:10];
      @(posedge clock);
    end
    d = {r[3:0], $urandom};
    {clk_en, clk_qualify_n} <= 2'b10;
    cs <= s ? 3'b010 : 3'b010 ^ (3'b100 >> ($urandom % 3));
    write_n <= ~w;
    advance_load <= adv;
    addr <= a;
    bw_n <= rb ? r[19:16] : 4'h0;
    wdata <= d;
    out_enable_n <= oe_n;
    if (!adv) begin
      cur_w = w;
      base = a;
      bc = 2'b00;
      active = s;
    end else begin
      bc = bc + 2'b01;
    end
    ea = {base[3:2], mode_strap ? base[1:0] ^ bc : base[1:0] + bc};
    if (active && cur_w) begin
      wcnt = wcnt + 1;
      for (k = 0; k < 4; k = k + 1) begin
        if (!(rb && r[16+k])) begin
          mem[ea][8*k+:8] = d[8*k+:8];
          mem[ea][32+k] = d[32+k];
        end
      end
    end else if (active && !oe_n && ctrl_on) begin
      mq.push_back(mem[ea]);
    end
    @(posedge clock);
  endtask
  task tap(input m, input d);
    tms <= m;
    tdi <= d;
    tck <= 1'b1;
    repeat (8) @(posedge clock);
    tck <= 1'b0;
    repeat (8) @(posedge clock);
  endtask
  task bursts(input [3:0] a);
    for (i = 0; i < 8; i = i + 1) op(1, i < 4, i % 4 != 0, 1, a);
    for (i = 0; i < 4; i = i + 1) op(1, 0, i != 0, 0, a);
    repeat (3) op(0, 0, 0, 0, 4'h0);
  endtask
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      fails = fails + 1;
      close_out;
    end
    if (avs_read && !avs_waitrequest)
      check(avs_readdata, bq.pop_front(), "reg");
    if (dq_oe && clk_en && !clk_qualify_n)
      check({par_out, dq_out}, mq.pop_front(), "word");
  end
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {resetn, clk_en, clk_qualify_n, advance_load, write_n} = 5'b01001;
    {cs, bw_n, addr, avs_address, wdata} = {3'b110, 4'hF, 44'h0};
    {out_enable_n, oe_n, mode_strap, tck, tms, tdi} = 6'b001010;
    {avs_read, avs_write, avs_writedata} = 34'h0;
    {fails, checks, cyc, wcnt, ctrl_on, active} = {128'h0, 2'b10};
    for (i = 0; i < 16; i = i + 1) mem[i] = 36'h0;
    r = $urandom(32'h5311);
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    bus(0, 4'h0, 0, 32'h1);
    bus(0, 4'h4, 0, 32'h9);
    bus(1, 4'hC, 32'hFFFFFFFF, 0);
    bus(0, 4'hC, 0, 0);
    $display("register test done");
    for (i = 0; i < 32; i = i + 1) op(1, i < 16, 0, 0, i[3:0]);
    for (i = 0; i < 16; i = i + 1) op(1, i % 2 == 0, 0, 1, i[3:1]);
    for (i = 0; i < 9; i = i + 1) op(i % 3 != 2, 0, 0, 0, i[3:0]);
    bursts(4'h6);
    $display("interleaved test done");
    oe_n = 1'b1;
    op(1, 0, 0, 0, 4'h3);
    repeat (2) op(0, 0, 0, 0, 4'h0);
    oe_n = 1'b0;
    bus(1, 4'h0, 32'h0, 0);
    ctrl_on = 1'b0;
    op(1, 0, 0, 0, 4'h5);
    repeat (2) op(0, 0, 0, 0, 4'h0);
    bus(1, 4'h0, 32'h1, 0);
    ctrl_on = 1'b1;
    bus(0, 4'h8, 0, wcnt);
    $display("output control test done");
    resetn <= 1'b0;
    mode_strap <= 1'b0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    wcnt = 0;
    repeat (4) op(0, 0, 0, 0, 4'h0);
    bus(0, 4'h4, 0, 32'h8);
    bursts(4'hD);
    bus(0, 4'h8, 0, wcnt);
    $display("linear test done");
    for (i = 0; i < 5; i = i + 1) tap(1, 0);
    tap(0, 0);
    bus(0, 4'h4, 0, 32'h0);
    tap(1, 0);
    tap(1, 0);
    tap(0, 0);
    tap(0, 0);
    check(tdo, 1'b1, "tdo");
    check(tdo_oe, 1'b1, "tdo_oe");
    r = $urandom;
    tap(0, r[0]);
    check(tdo, 1'b0, "tdo");
    tap(0, 0);
    check(tdo, r[0], "tdo");
    for (i = 0; i < 5; i = i + 1) tap(1, 0);
    bus(0, 4'h4, 0, 32'h8);
    $display("test port test done");
    check(mq.size(), 0, "reads left");
    close_out;
  end
endmodule
bind psd_sram psd_chk psd_chk_i (.clock, .resetn, .clk_en, .clk_qualify_n,
  .chip_select1_n, .chip_select2, .chip_select3_n, .advance_load, .write_n,
  .out_enable_n, .dq_out, .dq_oe, .parity_lane_oe, .tck, .tdo, .tdo_oe,
  .avs_read, .avs_write, .avs_waitrequest);
